/* File: hdl/ddrmr_pkg.sv */
// Package: field layout, codes and timing counts for the mode-register block
package ddrmr_pkg;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int COL_W = 3;
  // Mode register fields
  localparam int BL_LSB = 0;
  localparam int BT_POS = 3;
  localparam int CL_LSB = 4;
  localparam int TM_LSB = 7;
  // Extended register fields
  localparam int DLL_DIS_POS = 0;
  localparam int DRV_WEAK_POS = 1;
  // Burst length codes
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  // Latency codes
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_3 = 3'h3;
  localparam logic [2:0] CL_CODE_25 = 3'h6;
  // Test field codes
  localparam logic [1:0] TM_NORMAL = 2'h0;
  localparam logic [1:0] TM_DLL_RESET = 2'h2;
  // Reset values (device contents are undefined; zero chosen)
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] EXT_RST = 13'h0000;
  // Register-write settle time after a write
  localparam int WRITE_GAP_CYC = 2;
  // Default latency in half clocks after reset
  localparam logic [2:0] CL_HALF_RST = 3'h4;
  // Minimum access time in ns, and clock period
  localparam int ACCESS_TIME_NS = 15;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : ddrmr_pkg

/* File: hdl/ddrmr_if.sv */
// Interface: command and address pins between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface ddrmr_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic bank_select_low;
  logic bank_select_high;
  logic [ddrmr_pkg::ADDR_W-1:0] addr_bus;
  logic data_valid;
  logic [ddrmr_pkg::COL_W-1:0] data_col;
  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, addr_bus,
    input data_valid, data_col
  );
  modport mem (
    input cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, addr_bus,
    output data_valid, data_col
  );
endinterface : ddrmr_if
`default_nettype wire

/* File: hdl/ddrmr_burst_seq.sv */
// Burst column sequencer: sequential or interleaved order inside a burst
`timescale 1ns/1ps
`default_nettype none
module ddrmr_burst_seq (
  // Start and mode
  input wire logic [ddrmr_pkg::COL_W-1:0] start_col,
  input wire logic [2:0] beat,
  input wire logic [2:0] len_code,
  input wire logic interleave,
  // Result
  output logic [ddrmr_pkg::COL_W-1:0] col
);
  import ddrmr_pkg::*;
  wire [2:0] wrap_mask;
  wire [2:0] seq_off;
  wire [2:0] ilv_off;
  wire [2:0] off;
  // Low bits that wrap; a reserved length falls back to two beats
  assign wrap_mask = (len_code == BL_CODE_8) ? 3'h7 :
                     (len_code == BL_CODE_4) ? 3'h3 : 3'h1;
  assign seq_off = 3'(start_col + beat);
  assign ilv_off = start_col ^ beat;
  assign off = interleave ? ilv_off : seq_off;
  assign col = (start_col & ~wrap_mask) | (off & wrap_mask);
endmodule : ddrmr_burst_seq
`default_nettype wire

/* File: hdl/ddrmr_mem.sv */
// Memory end: mode and extended register capture, latency and burst order
//
// Contract
// - Two-beat order follows low start bit
// - Sequential counts up, wraps in block
// - Interleave offset is start xor beat
// - First read data after programmed latency
// - Latency codes 010, 011, 110 decoded
// - Controller picks smallest latency meeting access
// - Controller writes test field 00 normally
// - Test field 10 triggers loop reset
// - Bank bit low mode, high extended
// - Capture address and bank on command
// - Extended write needs idle, clock-enable high
// - Two cycles after extended write
// - Extended bit 1 sets drive strength
// - Extended bit 0 set disables loop
// - Controller writes extended after power up
// - Reprogramming allowed while banks idle
// - Mode field layout: length, order, latency
// - Length codes 001, 010, 011 decoded
// - Two cycles after mode write
`timescale 1ns/1ps
`default_nettype none
module ddrmr_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link
  ddrmr_if.mem link,
  // Register copies and decoded settings
  output logic [ddrmr_pkg::ADDR_W-1:0] mode_reg,
  output logic [ddrmr_pkg::ADDR_W-1:0] ext_reg,
  output logic [3:0] burst_len,
  output logic interleave,
  output logic [2:0] cl_half,
  output logic cl_reserved,
  output logic dll_enable,
  output logic drive_weak,
  output logic dll_reset_pulse
);
  import ddrmr_pkg::*;
  typedef enum logic [1:0] {DDRMR_IDLE, DDRMR_WAIT, DDRMR_BURST} ddrmr_state_t;
  ddrmr_state_t state_ff;
  ddrmr_state_t nxt_state;
  logic [ADDR_W-1:0] mode_ff;
  logic [ADDR_W-1:0] ext_ff;
  logic [3:0] blen_ff;
  logic ilv_ff;
  logic [2:0] clh_ff;
  logic clres_ff;
  logic dll_en_ff;
  logic weak_ff;
  logic dllrst_ff;
  logic [2:0] wait_ff;
  logic [2:0] beat_ff;
  logic [COL_W-1:0] start_ff;
  logic valid_ff;
  logic [COL_W-1:0] col_ff;
  logic [2:0] len_code_ff;
  wire cmd_sel;
  wire reg_write;
  wire mode_wr;
  wire ext_wr;
  wire read_cmd;
  wire [2:0] bl_code;
  wire [2:0] cl_code;
  wire [1:0] tm_code;
  wire [3:0] blen_dec;
  wire [2:0] clh_dec;
  wire clres_dec;
  wire [2:0] wait_init;
  wire [COL_W-1:0] seq_col;
  wire last_beat;
  // Command decode; all commands masked while chip select is high
  assign cmd_sel = link.cke && !link.cs_n;
  assign reg_write = cmd_sel && !link.ras_n && !link.cas_n && !link.we_n;
  assign mode_wr = reg_write && !link.bank_select_low;
  assign ext_wr = reg_write && link.bank_select_low;
  assign read_cmd = cmd_sel && link.ras_n && !link.cas_n && link.we_n;
  assign bl_code = link.addr_bus[BL_LSB +: 3];
  assign cl_code = link.addr_bus[CL_LSB +: 3];
  assign tm_code = link.addr_bus[TM_LSB +: 2];
  assign blen_dec = (bl_code == BL_CODE_2) ? 4'h2 :
                    (bl_code == BL_CODE_4) ? 4'h4 :
                    (bl_code == BL_CODE_8) ? 4'h8 : 4'h0;
  assign clh_dec = (cl_code == CL_CODE_2) ? 3'h4 :
                   (cl_code == CL_CODE_3) ? 3'h6 :
                   (cl_code == CL_CODE_25) ? 3'h5 : 3'h0;
  assign clres_dec = (clh_dec == 3'h0);
  // Whole clocks before first data; half clock modelled as round down
  assign wait_init = 3'(clh_ff >> 1);
  assign last_beat = (4'({1'b0, beat_ff}) + 4'h1 >= blen_ff);
  // Register capture; both banks idle is the controller's duty
  // rewrite any time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_RST;
      ext_ff <= EXT_RST;
    end else begin
      if (mode_wr) begin
        mode_ff <= link.addr_bus;
      end
      if (ext_wr) begin
        ext_ff <= link.addr_bus;
      end
    end
  end
  // Decoded mode fields held alongside the raw copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blen_ff <= 4'h2;
      ilv_ff <= 1'b0;
      clh_ff <= CL_HALF_RST;
      clres_ff <= 1'b0;
      len_code_ff <= BL_CODE_2;
    end else if (mode_wr) begin
      blen_ff <= blen_dec;
      ilv_ff <= link.addr_bus[BT_POS];
      clh_ff <= clh_dec;
      clres_ff <= clres_dec;
      len_code_ff <= bl_code;
    end
  end
  // Extended fields and loop reset strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dll_en_ff <= 1'b1;
      weak_ff <= 1'b0;
      dllrst_ff <= 1'b0;
    end else begin
      dllrst_ff <= mode_wr && (tm_code == TM_DLL_RESET);
      if (ext_wr) begin
        dll_en_ff <= !link.addr_bus[DLL_DIS_POS];
        weak_ff <= link.addr_bus[DRV_WEAK_POS];
      end
    end
  end
  // Read sequencer; a new read restarts a running burst (interrupts), one arriving during the wait is ignored
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DDRMR_IDLE: begin
        if (read_cmd && !clres_ff) begin
          nxt_state = (wait_init > 3'h1) ? DDRMR_WAIT : DDRMR_BURST;
        end
      end
      DDRMR_WAIT: begin
        if (wait_ff == 3'h1) begin
          nxt_state = DDRMR_BURST;
        end
      end
      DDRMR_BURST: begin
        if (read_cmd && !clres_ff) begin
          nxt_state = (wait_init > 3'h1) ? DDRMR_WAIT : DDRMR_BURST;
        end else if (last_beat) begin
          nxt_state = DDRMR_IDLE;
        end
      end
      default: nxt_state = DDRMR_IDLE;
    endcase
  end
  ddrmr_burst_seq ddrmr_burst_seq_inst (
    .start_col(start_ff),
    .beat(beat_ff),
    .len_code(len_code_ff),
    .interleave(ilv_ff),
    .col(seq_col)
  );
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= DDRMR_IDLE;
      wait_ff <= 3'h0;
      beat_ff <= 3'h0;
      start_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (read_cmd && !clres_ff && state_ff != DDRMR_WAIT) begin
        wait_ff <= 3'(wait_init - 3'h1);
        beat_ff <= 3'h0;
        start_ff <= link.addr_bus[COL_W-1:0];
      end else if (state_ff == DDRMR_WAIT) begin
        wait_ff <= 3'(wait_ff - 3'h1);
      end else if (state_ff == DDRMR_BURST) begin
        beat_ff <= 3'(beat_ff + 3'h1);
      end
    end
  end
  // Data beat outputs registered, so valid trails the sequencer state one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_ff <= 1'b0;
      col_ff <= '0;
    end else begin
      valid_ff <= (state_ff == DDRMR_BURST);
      col_ff <= seq_col;
    end
  end
  assign link.data_valid = valid_ff;
  assign link.data_col = col_ff;
  assign mode_reg = mode_ff;
  assign ext_reg = ext_ff;
  assign burst_len = blen_ff;
  assign interleave = ilv_ff;
  assign cl_half = clh_ff;
  assign cl_reserved = clres_ff;
  assign dll_enable = dll_en_ff;
  assign drive_weak = weak_ff;
  assign dll_reset_pulse = dllrst_ff;
endmodule : ddrmr_mem
`default_nettype wire

/* File: hdl/ddrmr_ctrl.sv */
// Controller end: issues register writes and reads with required spacing
`timescale 1ns/1ps
`default_nettype none
module ddrmr_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // User request
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [ddrmr_pkg::ADDR_W-1:0] req_addr,
  input wire logic banks_idle,
  output logic req_ready,
  // Returned read beats
  output logic rd_valid,
  output logic [ddrmr_pkg::COL_W-1:0] rd_col,
  // Link
  ddrmr_if.ctrl link
);
  import ddrmr_pkg::*;
  // Kinds: 0 mode write, 1 extended write, 2 read, 3 no-op
  logic [1:0] gap_ff;
  logic ready_ff;
  logic cs_n_ff;
  logic ras_n_ff;
  logic cas_n_ff;
  logic we_n_ff;
  logic bsl_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic rdv_ff;
  logic [COL_W-1:0] rdc_ff;
  wire is_wr;
  wire fire;
  wire [ADDR_W-1:0] wr_addr;
  wire [1:0] nxt_gap;
  assign is_wr = !req_kind[1];
  assign fire = req_valid && (gap_ff == 2'h0) && (!is_wr || banks_idle);
  // test field forced normal except loop reset
  assign wr_addr = (req_kind == 2'h0 && req_addr[TM_LSB +: 2] != TM_DLL_RESET)
                   ? (req_addr & ~(13'h0003 << TM_LSB)) : req_addr;
  assign nxt_gap = (fire && is_wr) ? 2'(WRITE_GAP_CYC) :
                   (gap_ff != 2'h0) ? 2'(gap_ff - 2'h1) : 2'h0;
  // Ready is registered so the user port comes straight from a flop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_ff <= 2'h0;
      ready_ff <= 1'b1;
    end else begin
      gap_ff <= nxt_gap;
      ready_ff <= (nxt_gap == 2'h0);
    end
  end
  // Command drive; idle cycles are no-ops with clock-enable held high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_n_ff <= 1'b1;
      ras_n_ff <= 1'b1;
      cas_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      bsl_ff <= 1'b0;
      addr_ff <= '0;
    end else begin
      cs_n_ff <= !(fire && req_kind != 2'h3);
      ras_n_ff <= !(fire && is_wr);
      cas_n_ff <= !(fire && req_kind != 2'h3);
      we_n_ff <= !(fire && is_wr);
      bsl_ff <= fire && (req_kind == 2'h1);
      addr_ff <= is_wr ? wr_addr : req_addr;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdv_ff <= 1'b0;
      rdc_ff <= '0;
    end else begin
      rdv_ff <= link.data_valid;
      rdc_ff <= link.data_col;
    end
  end
  assign req_ready = ready_ff;
  assign rd_valid = rdv_ff;
  assign rd_col = rdc_ff;
  assign link.cke = 1'b1;
  assign link.cs_n = cs_n_ff;
  assign link.ras_n = ras_n_ff;
  assign link.cas_n = cas_n_ff;
  assign link.we_n = we_n_ff;
  assign link.bank_select_low = bsl_ff;
  assign link.bank_select_high = 1'b0;
  assign link.addr_bus = addr_ff;
endmodule : ddrmr_ctrl
`default_nettype wire

/* File: verification/ddrmr_checker.sv */
// Checker: command spacing, read latency and burst order on the link
`timescale 1ns/1ps
`default_nettype none
module ddrmr_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command side
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ddrmr_pkg::ADDR_W-1:0] addr_bus,
  // Data side
  input wire logic data_valid,
  input wire logic [ddrmr_pkg::COL_W-1:0] data_col
);
  import ddrmr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Command decode
  wire wr = !cs_n && !ras_n && !cas_n && !we_n;
  wire rd = !cs_n && ras_n && !cas_n && we_n;
  logic [2:0] cl_ff, bl_ff, st_ff;
  logic bt_ff;
  logic [3:0] beat_ff;
  // Shadow of programmed fields; reset matches the memory's chosen defaults
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {cl_ff, bt_ff, bl_ff} <= {CL_CODE_2, 1'b0, BL_CODE_2};
      st_ff <= 3'h0;
      beat_ff <= 4'h0;
    end else begin
      if (wr && !bank_select_low) {cl_ff, bt_ff, bl_ff} <= addr_bus[6:0];
      if (rd) st_ff <= addr_bus[2:0];
      beat_ff <= data_valid ? beat_ff + 4'h1 : 4'h0;
    end
  end
  // Expected length, wrap mask and column of the current beat
  wire [3:0] len = (bl_ff == BL_CODE_8) ? 4'h8 : (bl_ff == BL_CODE_4) ? 4'h4 : 4'h2;
  wire [2:0] msk = len[2:0] - 3'h1;
  wire [2:0] off = bt_ff ? (st_ff ^ beat_ff[2:0]) : (st_ff + beat_ff[2:0]);
  wire [2:0] ecol = (st_ff & ~msk) | (off & msk);
  wire cl3 = (cl_ff == CL_CODE_3);
  wire cl2 = (cl_ff == CL_CODE_2) || (cl_ff == CL_CODE_25);
  sequence s_quiet2;
    !data_valid [*2];
  endsequence
  sequence s_quiet3;
    !data_valid [*3];
  endsequence
  a_cke_held: assert property (!cs_n |-> cke)
    else $error("command without clock enable");
  a_bank_high_low: assert property (!cs_n |-> !bank_select_high)
    else $error("reserved bank bit driven high");
  a_test_clear: assert property (wr && !bank_select_low |-> !addr_bus[7])
    else $error("test field code not allowed");
  a_write_gap: assert property (wr |=> cs_n [*2])
    else $error("command too soon after register write");
  a_first_cl2: assert property (rd && cl2 |=> s_quiet2 ##1 data_valid)
    else $error("first beat not at latency two");
  a_first_cl3: assert property (rd && cl3 |=> s_quiet3 ##1 data_valid)
    else $error("first beat not at latency three");
  a_reserved_read: assert property (rd && !cl2 && !cl3 |=> !data_valid [*8])
    else $error("data for read under reserved latency");
  a_burst_count: assert property ($fell(data_valid) |-> beat_ff == len)
    else $error("burst beat count wrong");
  a_col_order: assert property (data_valid |-> data_col == ecol)
    else $error("burst column order wrong");
endmodule : ddrmr_checker
`default_nettype wire

/* File: verification/ddr_mode_register_burst_order_tb.sv */
// Testbench: both ends joined, user side driven, link watched
`timescale 1ns/1ps
`default_nettype none
module ddr_mode_register_burst_order_tb;
  import ddrmr_pkg::*;
  // Latency codes and their half-clock values, last entry restores latency two
  localparam logic [11:0] CLS = {CL_CODE_3, CL_CODE_25, 3'h0, CL_CODE_2};
  localparam logic [11:0] HALF = 12'hd44;
  // smallest whole latency meeting access time
  localparam logic [2:0] CL_PICK = (ACCESS_CYC <= 2) ? CL_CODE_2 : CL_CODE_3;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic banks_idle = 1'b1;
  logic [1:0] req_kind = 2'h3;
  logic [ADDR_W-1:0] req_addr = 13'h0000;
  logic [31:0] rng = 32'h00003f9c; // Seed 16284
  logic [2:0] exp_q[$];
  int num_errors = 0;
  int comparisons = 0;
  int pulse_cnt = 0;
  wire req_ready, rd_valid, interleave, cl_reserved, dll_enable, drive_weak, dll_reset_pulse;
  wire [2:0] rd_col, cl_half;
  wire [3:0] burst_len;
  wire [ADDR_W-1:0] mode_reg, ext_reg;
  ddrmr_if lk ();
  ddrmr_ctrl ddrmr_ctrl_inst (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .banks_idle(banks_idle),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_col(rd_col), .link(lk));
  ddrmr_mem ddrmr_mem_inst (.core_clk(core_clk), .rst(rst), .link(lk), .mode_reg(mode_reg),
    .ext_reg(ext_reg), .burst_len(burst_len), .interleave(interleave), .cl_half(cl_half),
    .cl_reserved(cl_reserved), .dll_enable(dll_enable), .drive_weak(drive_weak),
    .dll_reset_pulse(dll_reset_pulse));
  ddrmr_checker ddrmr_checker_inst (.core_clk(core_clk), .rst(rst), .cke(lk.cke),
    .cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n),
    .bank_select_low(lk.bank_select_low), .bank_select_high(lk.bank_select_high),
    .addr_bus(lk.addr_bus), .data_valid(lk.data_valid), .data_col(lk.data_col));
  initial forever #20 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [2:0] ecol(input logic [2:0] s, b, m, input logic il);
    return (s & ~m) | ((il ? s ^ b : s + b) & m);
  endfunction : ecol
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic fail_wait(input string nm);
    num_errors++;
    $display("[FAIL] %s expected 1 seen 0", nm);
    finish_test();
  endtask : fail_wait
  // Inputs always move 1 ns after the edge, away from sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // Hold the request until ready is seen, then leave room for the write gap
  task automatic do_req(input logic [1:0] k, input logic [12:0] a);
    int n;
    n = 0;
    req_kind = k;
    req_addr = a;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n == 20) fail_wait("req_ready");
    cyc(1);
    req_valid = 1'b0;
    cyc(3);
  endtask : do_req
  // Note the expected columns, issue the read, wait for all beats
  task automatic rd_burst(input logic [2:0] s, input int n, input logic il);
    int w;
    for (int b = 0; b < n; b++) exp_q.push_back(ecol(s, 3'(b), 3'(n - 1), il));
    do_req(2'h2, {10'h000, s});
    w = 0;
    while (exp_q.size() != 0 && w < 40) begin
      cyc(1);
      w++;
    end
    if (w == 40) fail_wait("burst end");
    cyc(10);
  endtask : rd_burst
  // Watcher: each returned beat takes the oldest note; stray beats fail
  always @(posedge core_clk) begin
    pulse_cnt += int'(dll_reset_pulse === 1'b1);
    if (rd_valid === 1'b1 && exp_q.size() == 0) chk("rd_valid", 13'h0000, 13'h0001);
    else if (rd_valid === 1'b1) chk("rd_col", {10'h000, exp_q.pop_front()}, {10'h000, rd_col});
  end
  initial begin
    logic [12:0] a;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    chk("cl_half", 13'h0004, {10'h000, cl_half});
    do_req(2'h1, 13'h0000);
    chk("dll_enable", 13'h0001, {12'h000, dll_enable});
    $display("Test reset done");
    for (int c = 1; c < 4; c++) begin
      for (int i = 0; i < 2; i++) begin
        a = {6'h00, CL_PICK, i[0], c[2:0]};
        rng = xs(rng);
        do_req(2'h0, a);
        chk("mode_reg", a, mode_reg);
        chk("burst_len", 13'h0001 << c, {9'h000, burst_len});
        chk("interleave", {12'h000, i[0]}, {12'h000, interleave});
        rd_burst(rng[2:0], 1 << c, i[0]);
      end
    end
    $display("Test burst_order done");
    for (int j = 3; j >= 0; j--) begin
      do_req(2'h0, {6'h00, CLS[3*j +: 3], 1'b0, BL_CODE_4});
      chk("cl_half", {10'h000, HALF[3*j +: 3]}, {10'h000, cl_half});
      chk("cl_reserved", {12'h000, j == 1}, {12'h000, cl_reserved});
      rd_burst(3'h2, j == 1 ? 0 : 4, 1'b0);
    end
    $display("Test latency done");
    for (int j = 0; j < 4; j++) begin
      do_req(2'h1, {11'h000, j[1:0]});
      chk("ext_reg", {11'h000, j[1:0]}, ext_reg);
      chk("dll_enable", {12'h000, !j[0]}, {12'h000, dll_enable});
      chk("drive_weak", {12'h000, j[1]}, {12'h000, drive_weak});
      chk("mode_reg", 13'h0022, mode_reg);
    end
    $display("Test extended done");
    do_req(2'h0, 13'h0122);
    chk("dll_reset_pulse", 13'h0001, pulse_cnt[12:0]);
    do_req(2'h0, 13'h00a2);
    chk("test_bits", 13'h0000, {11'h000, mode_reg[8:7]});
    chk("dll_reset_pulse", 13'h0001, pulse_cnt[12:0]);
    $display("Test dll_reset done");
    // Write held while banks are busy must not land
    banks_idle = 1'b0;
    req_kind = 2'h0;
    req_addr = 13'h0033;
    req_valid = 1'b1;
    cyc(4);
    req_valid = 1'b0;
    banks_idle = 1'b1;
    cyc(3);
    chk("mode_reg", 13'h0022, mode_reg);
    // No-op request must leave the link idle
    do_req(2'h3, 13'h0055);
    chk("mode_reg", 13'h0022, mode_reg);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk("burst_len", 13'h0002, {9'h000, burst_len});
    chk("ext_reg", 13'h0000, ext_reg);
    $display("Test busy_and_reset done");
    finish_test();
  end
endmodule : ddr_mode_register_burst_order_tb
`default_nettype wire
